// *** logic/cmd_parser_pkg.sv ***
// Constants, types and reply records shared by the host command parser
//
// Summary of operation
// - Binary commands hold at most 22 bytes, ASCII commands at most 48 characters.
// - The first byte gives the whole command length and marks completion.
// - The second byte is the opcode and selects the payload class.
// - ASCII bytes arrive as two hex digits, either case, joined into one byte.
// - An ASCII command completes only after carriage return then line feed.
// - Binary and ASCII commands may mix; each frame picks its own format.
// - With replies anytime set, every command except a reset replies, by default with OK.
// - The OK reply is the two bytes 02 01.
// - Only one command is handled at a time.
// - Request-to-send stays high while a command is processed.
// - Opcodes 02, 03, 04 configure, set and get pins.
// - Opcode 01 configures the slave, 05 feeds the radio, 06 the UI server.
// - Opcodes 07 to 0A fetch UI info and read, set or write controls.
// - Opcodes 0B, 0C, 0D overwrite, append and time-stamp append matrix rows.
// - Opcodes 0E and 0F read and write memory.
// - Opcode 40 releases the next queued reply when replies wait for it.
// - Opcode 00 requests a full device reset.
// - A zero length byte resets at once in either format.
// - Illegal characters give error reply 03 02 F1 and restart framing.
// - Delete and carriage return are ordinary data inside a binary frame.
// - Each reply queue entry holds 22 bytes.
// - When enabled, a pin shows whether replies wait in the queue.
`default_nettype none
package cmd_parser_pkg;

   localparam int BIN_MAX_BYTES   = 22;
   localparam int ASCII_MAX_CHARS = 48;
   localparam int ASCII_MAX_BYTES = ASCII_MAX_CHARS / 2;
   localparam int BUF_BYTES       = ASCII_MAX_BYTES;
   localparam int REPLY_BYTES     = 22;
   localparam int QUEUE_DEPTH     = 8;

   localparam logic [7:0] BIN_MAX_LEN   = 8'h16;
   localparam logic [7:0] ASCII_MAX_LEN = 8'h18;
   localparam logic [7:0] MIN_LEN       = 8'h02;
   localparam logic [7:0] CHAR_CR       = 8'h0D;
   localparam logic [7:0] CHAR_LF       = 8'h0A;
   localparam logic [7:0] NIB_ALPHA_ADJ = 8'h09;

   localparam logic [7:0] OP_RESET      = 8'h00;
   localparam logic [7:0] OP_CONFIG     = 8'h01;
   localparam logic [7:0] OP_IO_CONFIG  = 8'h02;
   localparam logic [7:0] OP_IO_GET     = 8'h04;
   localparam logic [7:0] OP_RADIO      = 8'h05;
   localparam logic [7:0] OP_UI_FWD     = 8'h06;
   localparam logic [7:0] OP_UI_INFO    = 8'h07;
   localparam logic [7:0] OP_CTL_WRITE  = 8'h0A;
   localparam logic [7:0] OP_ROW_SET    = 8'h0B;
   localparam logic [7:0] OP_ROW_LOG    = 8'h0D;
   localparam logic [7:0] OP_MEM_READ   = 8'h0E;
   localparam logic [7:0] OP_MEM_WRITE  = 8'h0F;
   localparam logic [7:0] OP_NEXT_REPLY = 8'h40;

   typedef enum logic [8:0] {
      ST_IDLE    = 9'h001,
      ST_BIN     = 9'h002,
      ST_ASC     = 9'h004,
      ST_TERM_CR = 9'h008,
      ST_TERM_LF = 9'h010,
      ST_CHECK   = 9'h020,
      ST_EXEC    = 9'h040,
      ST_ERR     = 9'h080,
      ST_REPLY   = 9'h100
   } state_type;

   typedef enum logic [3:0] {
      CLS_NONE    = 4'h0,
      CLS_RESET   = 4'h1,
      CLS_CONFIG  = 4'h2,
      CLS_IO      = 4'h3,
      CLS_FORWARD = 4'h4,
      CLS_CONTROL = 4'h5,
      CLS_MATRIX  = 4'h6,
      CLS_MEMORY  = 4'h7,
      CLS_QUEUE   = 4'h8
   } cls_type;

   typedef struct packed {
      logic [7:0] len;
      logic [7:0] op;
      cls_type    cls;
      logic       ascii;
   } cmd_info_type;

   typedef struct packed {
      logic [4:0]                  len;
      logic [REPLY_BYTES-1:0][7:0] body;
   } reply_type;

   localparam int REPLY_W = $bits(reply_type);

   localparam reply_type REPLY_OK  = '{len: 5'h02, body: {160'h0, 8'h01, 8'h02}};
   localparam reply_type REPLY_ERR = '{len: 5'h03, body: {152'h0, 8'hF1, 8'h02, 8'h03}};

endpackage
`default_nettype wire

// *** logic/serial_host_command_parser.sv ***
// Host command parser with reply queue and byte transmitter
`timescale 1ns/1ps
`default_nettype none

module reply_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wr_ptr_ff;
   logic [AW:0]      rd_ptr_ff;
   wire              full;
   wire              empty;
   wire              push;
   wire              pop;

   assign full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
   assign empty       = (wr_ptr_ff == rd_ptr_ff);
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = mem_ff[rd_ptr_ff[AW-1:0]];
   assign push        = i_in_valid && !full;
   assign pop         = i_out_ready && !empty;

   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
         rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
      end
   end
endmodule

module serial_host_command_parser (
   input  wire logic                                      i_clk_sys,
   input  wire logic                                      i_rst,
   input  wire logic [7:0]                                i_rx_byte,
   input  wire logic                                      i_rx_valid,
   input  wire logic                                      i_replies_anytime,
   input  wire logic                                      i_pending_flag_pin_option,
   input  wire logic                                      i_cmd_done,
   input  wire logic                                      i_cmd_has_result,
   input  wire cmd_parser_pkg::reply_type                 i_cmd_reply,
   input  wire logic                                      i_tx_ready,
   output logic                                           o_rts,
   output logic                                           o_cmd_valid,
   output cmd_parser_pkg::cmd_info_type                   o_cmd_info,
   output logic [cmd_parser_pkg::BUF_BYTES-1:0][7:0]      o_cmd_body,
   output logic                                           o_reset_req,
   output logic [7:0]                                     o_tx_byte,
   output logic                                           o_tx_valid,
   output logic                                           o_queue_pending
);
   import cmd_parser_pkg::*;

   state_type                   state_ff;
   logic [BUF_BYTES-1:0][7:0]   buf_ff;
   logic [4:0]                  cnt_ff;
   logic [7:0]                  len_ff;
   logic [3:0]                  nib_hi_ff;
   logic                        half_ff;
   logic                        ascii_ff;
   logic                        rts_ff;
   logic                        cmd_valid_ff;
   cmd_info_type                cmd_info_ff;
   logic                        reset_req_ff;
   reply_type                   reply_ff;
   logic                        want_ff;
   logic                        credit_ff;
   logic                        tx_busy_ff;
   reply_type                   tx_entry_ff;
   logic [4:0]                  tx_idx_ff;
   logic [7:0]                  tx_byte_ff;
   logic                        tx_valid_ff;
   logic                        pending_ff;

   wire                         is_dig;
   wire                         is_upper;
   wire                         is_lower;
   wire                         is_hex;
   wire  [3:0]                  nib;
   wire  [7:0]                  asc_byte;
   wire  [7:0]                  op;
   cls_type                     op_cls;
   wire                         op_known;
   wire                         last_byte;
   wire                         set_credit;
   wire                         fifo_in_ready;
   wire                         fifo_in_valid;
   wire                         fifo_out_valid;
   reply_type                   fifo_out_data;
   wire                         pop;
   wire                         advance;

   // Hex digit recognition accepts both letter cases
   assign is_dig   = (i_rx_byte >= 8'h30) && (i_rx_byte <= 8'h39);
   assign is_upper = (i_rx_byte >= 8'h41) && (i_rx_byte <= 8'h46);
   assign is_lower = (i_rx_byte >= 8'h61) && (i_rx_byte <= 8'h66);
   assign is_hex   = is_dig || is_upper || is_lower;
   assign nib      = is_dig ? i_rx_byte[3:0] : 4'(i_rx_byte[3:0] + NIB_ALPHA_ADJ[3:0]);
   assign asc_byte = {nib_hi_ff, nib};

   assign op       = buf_ff[1];
   assign op_cls   = (op == OP_RESET)                              ? CLS_RESET   :
                     (op == OP_CONFIG)                             ? CLS_CONFIG  :
                     (op >= OP_IO_CONFIG && op <= OP_IO_GET)       ? CLS_IO      :
                     (op == OP_RADIO || op == OP_UI_FWD)           ? CLS_FORWARD :
                     (op >= OP_UI_INFO && op <= OP_CTL_WRITE)      ? CLS_CONTROL :
                     (op >= OP_ROW_SET && op <= OP_ROW_LOG)        ? CLS_MATRIX  :
                     (op == OP_MEM_READ || op == OP_MEM_WRITE)     ? CLS_MEMORY  :
                     (op == OP_NEXT_REPLY)                         ? CLS_QUEUE   :
                                                                     CLS_NONE;
   assign op_known   = (op_cls != CLS_NONE);
   assign last_byte  = (({3'h0, cnt_ff} + 8'h01) == len_ff);
   assign set_credit = (state_ff == ST_CHECK) && (op_cls == CLS_QUEUE);

   // Frame parser; bytes arriving while busy are ignored
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_ff     <= ST_IDLE;
         buf_ff       <= '0;
         cnt_ff       <= 5'h00;
         len_ff       <= 8'h00;
         nib_hi_ff    <= 4'h0;
         half_ff      <= 1'b0;
         ascii_ff     <= 1'b0;
         rts_ff       <= 1'b0;
         cmd_valid_ff <= 1'b0;
         cmd_info_ff  <= '0;
         reset_req_ff <= 1'b0;
         reply_ff     <= '0;
         want_ff      <= 1'b0;
      end else begin
         cmd_valid_ff <= 1'b0;
         reset_req_ff <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (i_rx_valid) begin
                  cnt_ff  <= 5'h01;
                  len_ff  <= i_rx_byte;
                  buf_ff[0] <= i_rx_byte;
                  if (i_rx_byte == OP_RESET) begin
                     reset_req_ff <= 1'b1;
                  end else if (i_rx_byte < MIN_LEN) begin
                     state_ff <= ST_ERR;
                     rts_ff   <= 1'b1;
                  end else if (i_rx_byte <= BIN_MAX_LEN) begin
                     ascii_ff <= 1'b0;
                     state_ff <= ST_BIN;
                  end else if (is_hex) begin
                     ascii_ff  <= 1'b1;
                     cnt_ff    <= 5'h00;
                     nib_hi_ff <= nib;
                     half_ff   <= 1'b1;
                     state_ff  <= ST_ASC;
                  end else begin
                     state_ff <= ST_ERR;
                     rts_ff   <= 1'b1;
                  end
               end
            end
            ST_BIN: begin
               if (i_rx_valid) begin
                  // Any byte value, delete and carriage return included, is data
                  buf_ff[cnt_ff] <= i_rx_byte;
                  cnt_ff         <= cnt_ff + 5'h01;
                  if (last_byte) begin
                     state_ff <= ST_CHECK;
                     rts_ff   <= 1'b1;
                  end
               end
            end
            ST_ASC: begin
               if (i_rx_valid) begin
                  if (!is_hex) begin
                     state_ff <= ST_ERR;
                     rts_ff   <= 1'b1;
                  end else if (!half_ff) begin
                     nib_hi_ff <= nib;
                     half_ff   <= 1'b1;
                  end else begin
                     half_ff        <= 1'b0;
                     buf_ff[cnt_ff] <= asc_byte;
                     cnt_ff         <= cnt_ff + 5'h01;
                     if (cnt_ff == 5'h00) begin
                        len_ff <= asc_byte;
                        if (asc_byte == OP_RESET) begin
                           reset_req_ff <= 1'b1;
                           state_ff     <= ST_IDLE;
                        end else if (asc_byte < MIN_LEN || asc_byte > ASCII_MAX_LEN) begin
                           state_ff <= ST_ERR;
                           rts_ff   <= 1'b1;
                        end
                     end else if (last_byte) begin
                        state_ff <= ST_TERM_CR;
                     end
                  end
               end
            end
            ST_TERM_CR: begin
               if (i_rx_valid) begin
                  state_ff <= (i_rx_byte == CHAR_CR) ? ST_TERM_LF : ST_ERR;
                  rts_ff   <= (i_rx_byte != CHAR_CR);
               end
            end
            ST_TERM_LF: begin
               if (i_rx_valid) begin
                  state_ff <= (i_rx_byte == CHAR_LF) ? ST_CHECK : ST_ERR;
                  rts_ff   <= 1'b1;
               end
            end
            ST_CHECK: begin
               if (!op_known) begin
                  state_ff <= ST_ERR;
               end else if (op_cls == CLS_RESET) begin
                  reset_req_ff <= 1'b1;
                  state_ff     <= ST_IDLE;
                  rts_ff       <= 1'b0;
               end else if (op_cls == CLS_QUEUE) begin
                  reply_ff <= REPLY_OK;
                  want_ff  <= i_replies_anytime;
                  state_ff <= ST_REPLY;
               end else begin
                  cmd_valid_ff      <= 1'b1;
                  cmd_info_ff.len   <= len_ff;
                  cmd_info_ff.op    <= op;
                  cmd_info_ff.cls   <= op_cls;
                  cmd_info_ff.ascii <= ascii_ff;
                  state_ff          <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (i_cmd_done) begin
                  reply_ff <= i_cmd_has_result ? i_cmd_reply : REPLY_OK;
                  want_ff  <= i_cmd_has_result || i_replies_anytime;
                  state_ff <= ST_REPLY;
               end
            end
            ST_ERR: begin
               reply_ff <= REPLY_ERR;
               want_ff  <= 1'b1;
               state_ff <= ST_REPLY;
            end
            ST_REPLY: begin
               // A full queue holds the parser here with request-to-send high
               if (!want_ff || fifo_in_ready) begin
                  want_ff  <= 1'b0;
                  state_ff <= ST_IDLE;
                  rts_ff   <= 1'b0;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
               rts_ff   <= 1'b0;
            end
         endcase
      end
   end

   assign fifo_in_valid = (state_ff == ST_REPLY) && want_ff;

   reply_fifo #(
      .WIDTH (REPLY_W),
      .DEPTH (QUEUE_DEPTH)
   ) u_queue (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_in_valid  (fifo_in_valid),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (reply_ff),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (pop),
      .o_out_data  (fifo_out_data)
   );

   // Replies leave at once, or one per release opcode when held back
   assign pop     = !tx_busy_ff && fifo_out_valid && (i_replies_anytime || credit_ff);
   assign advance = !tx_valid_ff || i_tx_ready;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         credit_ff <= 1'b0;
      end else begin
         credit_ff <= set_credit || (credit_ff && !(pop && !i_replies_anytime));
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         tx_busy_ff  <= 1'b0;
         tx_entry_ff <= '0;
         tx_idx_ff   <= 5'h00;
         tx_byte_ff  <= 8'h00;
         tx_valid_ff <= 1'b0;
      end else if (pop) begin
         tx_busy_ff  <= 1'b1;
         tx_entry_ff <= fifo_out_data;
         tx_idx_ff   <= 5'h00;
         tx_valid_ff <= tx_valid_ff && !i_tx_ready;
      end else if (tx_busy_ff && advance) begin
         if (tx_idx_ff < tx_entry_ff.len) begin
            tx_byte_ff  <= tx_entry_ff.body[tx_idx_ff];
            tx_valid_ff <= 1'b1;
            tx_idx_ff   <= tx_idx_ff + 5'h01;
         end else begin
            tx_busy_ff  <= 1'b0;
            tx_valid_ff <= 1'b0;
         end
      end else if (advance) begin
         tx_valid_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pending_ff <= 1'b0;
      end else begin
         pending_ff <= i_pending_flag_pin_option && fifo_out_valid;
      end
   end

   assign o_rts           = rts_ff;
   assign o_cmd_valid     = cmd_valid_ff;
   assign o_cmd_info      = cmd_info_ff;
   assign o_cmd_body      = buf_ff;
   assign o_reset_req     = reset_req_ff;
   assign o_tx_byte       = tx_byte_ff;
   assign o_tx_valid      = tx_valid_ff;
   assign o_queue_pending = pending_ff;

   property p_rts_exec;
      @(posedge i_clk_sys) disable iff (i_rst)
      (state_ff == ST_EXEC) || (state_ff == ST_CHECK) |-> o_rts;
   endproperty
   a_rts_exec: assert property (p_rts_exec) else $error("rts low during processing");

   property p_one_cmd;
      @(posedge i_clk_sys) disable iff (i_rst)
      o_cmd_valid |-> ##1 (!o_cmd_valid && o_rts);
   endproperty
   a_one_cmd: assert property (p_one_cmd) else $error("second command while busy");

   property p_zero_len;
      @(posedge i_clk_sys) disable iff (i_rst)
      (state_ff == ST_IDLE) && i_rx_valid && (i_rx_byte == OP_RESET) |=> o_reset_req && !o_rts;
   endproperty
   a_zero_len: assert property (p_zero_len) else $error("zero length did not reset");

   property p_illegal_char;
      @(posedge i_clk_sys) disable iff (i_rst)
      (state_ff == ST_ASC) && i_rx_valid && !is_hex
         |=> ##1 ((state_ff == ST_REPLY) && (reply_ff == REPLY_ERR) && want_ff);
   endproperty
   a_illegal_char: assert property (p_illegal_char) else $error("no error reply");

   property p_ok_reply;
      @(posedge i_clk_sys) disable iff (i_rst)
      (state_ff == ST_EXEC) && i_cmd_done && !i_cmd_has_result && i_replies_anytime
         |=> (reply_ff == REPLY_OK) && want_ff;
   endproperty
   a_ok_reply: assert property (p_ok_reply) else $error("missing ok reply");

   property p_pending_pin;
      @(posedge i_clk_sys) disable iff (i_rst)
      i_pending_flag_pin_option && fifo_out_valid |=> o_queue_pending;
   endproperty
   a_pending_pin: assert property (p_pending_pin) else $error("pending pin low");

   property p_release;
      @(posedge i_clk_sys) disable iff (i_rst)
      set_credit |=> credit_ff;
   endproperty
   a_release: assert property (p_release) else $error("release opcode lost");

   property p_bad_op;
      @(posedge i_clk_sys) disable iff (i_rst)
      (state_ff == ST_CHECK) && !op_known |=> (state_ff == ST_ERR) ##1 (reply_ff == REPLY_ERR);
   endproperty
   a_bad_op: assert property (p_bad_op) else $error("unknown opcode accepted");

   property p_crlf;
      @(posedge i_clk_sys) disable iff (i_rst)
      (state_ff == ST_TERM_LF) && i_rx_valid && (i_rx_byte == CHAR_LF) |=> (state_ff == ST_CHECK);
   endproperty
   a_crlf: assert property (p_crlf) else $error("terminator not accepted");

   property p_bin_len;
      @(posedge i_clk_sys) disable iff (i_rst)
      (state_ff == ST_BIN) && i_rx_valid && last_byte |=> (state_ff == ST_CHECK) && o_rts;
   endproperty
   a_bin_len: assert property (p_bin_len) else $error("length did not end frame");

   property p_mem_cls;
      @(posedge i_clk_sys) disable iff (i_rst)
      o_cmd_valid && (o_cmd_info.op == OP_MEM_READ) |-> (o_cmd_info.cls == CLS_MEMORY);
   endproperty
   a_mem_cls: assert property (p_mem_cls) else $error("memory opcode misclassed");

endmodule

`default_nettype wire

// *** test/host_term_model.sv ***
// Far-end host model: takes reply bytes with periodic stalls of its ready
`timescale 1ns/1ps
`default_nettype none
module host_term_model (
   input  wire logic       i_clk_sys,
   input  wire logic [7:0] i_tx_byte,
   input  wire logic       i_tx_valid,
   output logic            o_tx_ready
);
   logic [7:0] got_q[$];
   logic [2:0] stall_ff = 3'h0;
   initial o_tx_ready = 1'b0;
   always @(negedge i_clk_sys) begin
      stall_ff <= stall_ff + 3'h1;
      o_tx_ready <= (stall_ff != 3'h3) && (stall_ff != 3'h4);
   end
   always @(posedge i_clk_sys) begin
      if (i_tx_valid && o_tx_ready) begin
         got_q.push_back(i_tx_byte);
      end
   end
endmodule
`default_nettype wire

// *** test/serial_host_command_parser_bench.sv ***
// Self-checking bench for the host command parser
`timescale 1ns/1ps
`default_nettype none
module serial_host_command_parser_bench;
   import cmd_parser_pkg::*;
   logic clk, rst, rx_valid, anytime, pin_opt, done, has_res, rts, cmd_valid, reset_req;
   logic tx_valid, tx_ready, q_pend, res_mode;
   logic [7:0] rx_byte, tx_byte;
   reply_type reply;
   cmd_info_type info;
   logic [BUF_BYTES-1:0][7:0] body;
   int error_cnt = 0, total_checks = 0, cycles = 0;
   logic [31:0] lfsr = 32'hFBBCD8EE;
   logic [7:0] exp_q[$], q[$];
   serial_host_command_parser uut (.i_clk_sys(clk), .i_rst(rst), .i_rx_byte(rx_byte),
      .i_rx_valid(rx_valid), .i_replies_anytime(anytime), .i_pending_flag_pin_option(pin_opt),
      .i_cmd_done(done), .i_cmd_has_result(has_res), .i_cmd_reply(reply), .i_tx_ready(tx_ready),
      .o_rts(rts), .o_cmd_valid(cmd_valid), .o_cmd_info(info), .o_cmd_body(body),
      .o_reset_req(reset_req), .o_tx_byte(tx_byte), .o_tx_valid(tx_valid), .o_queue_pending(q_pend));
   host_term_model host (.i_clk_sys(clk), .i_tx_byte(tx_byte), .i_tx_valid(tx_valid),
      .o_tx_ready(tx_ready));
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction
   function automatic logic [7:0] hexc(logic [3:0] n, bit lc);
      return (n < 4'hA) ? 8'h30 + {4'h0, n} : (lc ? 8'h57 : 8'h37) + {4'h0, n};
   endfunction
   function automatic cls_type exp_cls(logic [7:0] o);
      if (o == 8'h01) return CLS_CONFIG;
      if (o <= 8'h04) return CLS_IO;
      if (o <= 8'h06) return CLS_FORWARD;
      if (o <= 8'h0A) return CLS_CONTROL;
      if (o <= 8'h0D) return CLS_MATRIX;
      return CLS_MEMORY;
   endfunction
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_replies();
      int n = 0;
      while (host.got_q.size() < exp_q.size() && n < 400) begin @(negedge clk); n++; end
      chk(host.got_q.size(), exp_q.size(), "reply count");
      foreach (exp_q[i]) if (i < host.got_q.size()) chk(host.got_q[i], exp_q[i], "reply byte");
      host.got_q.delete();
      exp_q.delete();
   endtask
   task automatic wait_lvl(ref logic s, input logic v, input string what);
      int n = 0;
      while (s !== v && n < 60) begin @(negedge clk); n++; end
      chk(s, v, what);
   endtask
   task automatic put(logic [7:0] b);
      @(negedge clk);
      rx_byte = b; rx_valid = 1'b1;
      @(negedge clk);
      rx_valid = 1'b0;
   endtask
   task automatic send(logic [7:0] f[$], bit asc, bit term);
      foreach (f[i]) begin
         if (asc) begin put(hexc(f[i][7:4], i[0])); put(hexc(f[i][3:0], !i[0])); end
         else put(f[i]);
      end
      if (asc && term) begin put(CHAR_CR); put(CHAR_LF); end
   endtask
   task automatic run_cmd(logic [7:0] f[$], bit asc, bit err);
      send(f, asc, 1'b1);
      if (err) begin
         exp_q.push_back(8'h03); exp_q.push_back(8'h02); exp_q.push_back(8'hF1);
      end else begin
         wait_lvl(cmd_valid, 1'b1, "command decoded");
         chk(info.op, f[1], "opcode");
         chk(info.len, f[0], "length");
         chk(info.cls, exp_cls(f[1]), "class");
         chk(info.ascii, asc, "format");
         chk(body[f[0]-1], f[f[0]-1], "last byte");
         chk(rts, 1'b1, "busy");
         reply.len = 5'h03;
         for (int i = 0; i < 3; i++) reply.body[i] = rnd();
         done = 1'b1; has_res = res_mode;
         @(negedge clk);
         done = 1'b0;
         if (res_mode) for (int i = 0; i < 3; i++) exp_q.push_back(reply.body[i]);
         else if (anytime) begin exp_q.push_back(8'h02); exp_q.push_back(8'h01); end
      end
      wait_lvl(rts, 1'b0, "idle again");
   endtask
   task automatic do_reset(logic [7:0] f[$], bit asc, bit term);
      send(f, asc, term);
      wait_lvl(reset_req, 1'b1, "reset request");
      wait_lvl(rts, 1'b0, "idle after reset");
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         error_cnt++;
         $display("BAD t=%0t run too long", $time);
         conclude();
      end
   end
   initial begin
      rst = 1'b1; rx_valid = 1'b0; rx_byte = 8'h00; anytime = 1'b1; pin_opt = 1'b1;
      done = 1'b0; has_res = 1'b0; res_mode = 1'b0; reply = '0;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      for (int op = 1; op < 16; op++) begin
         anytime = rnd() > 8'h3F;
         res_mode = anytime && (rnd() > 8'h7F);
         pin_opt = rnd() > 8'h7F;
         run_cmd({8'h04, 8'(op), rnd(), rnd()}, op[0], 1'b0);
         chk_replies();
      end
      $display("opcode sweep done");
      anytime = 1'b1;
      res_mode = 1'b0;
      pin_opt = 1'b1;
      run_cmd({8'h04, 8'h03, 8'h0D, 8'h7F}, 1'b0, 1'b0);
      q = {8'h16, 8'h0F};
      repeat (20) q.push_back(rnd());
      run_cmd(q, 1'b0, 1'b0);
      run_cmd(q, 1'b1, 1'b0);
      chk_replies();
      $display("framing tests done");
      run_cmd({8'h02, 8'h20}, 1'b0, 1'b1);
      run_cmd({8'h17}, 1'b0, 1'b1);
      put(8'h30); put(8'h33); put(8'h7A);
      exp_q.push_back(8'h03); exp_q.push_back(8'h02); exp_q.push_back(8'hF1);
      wait_lvl(rts, 1'b0, "idle after bad char");
      chk_replies();
      $display("error tests done");
      do_reset({8'h00}, 1'b0, 1'b0);
      do_reset({8'h00}, 1'b1, 1'b0);
      do_reset({8'h02, 8'h00}, 1'b0, 1'b0);
      do_reset({8'h02, 8'h00}, 1'b1, 1'b1);
      chk_replies();
      $display("reset tests done");
      anytime = 1'b0; res_mode = 1'b1;
      run_cmd({8'h03, 8'h04, 8'h01}, 1'b0, 1'b0);
      chk(host.got_q.size(), 0, "held reply");
      pin_opt = 1'b0;
      repeat (3) @(negedge clk);
      chk(q_pend, 1'b0, "pending masked");
      pin_opt = 1'b1;
      wait_lvl(q_pend, 1'b1, "pending flag");
      send({8'h02, 8'h40}, 1'b0, 1'b1);
      wait_lvl(rts, 1'b0, "idle after release");
      chk_replies();
      wait_lvl(q_pend, 1'b0, "pending clear");
      $display("queue tests done");
      anytime = 1'b1;
      res_mode = 1'b0;
      put(8'h05);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      chk(rts, 1'b0, "rts after reset");
      run_cmd({8'h03, 8'h0E, rnd()}, 1'b0, 1'b0);
      chk_replies();
      $display("reset recovery done");
      conclude();
   end
endmodule
`default_nettype wire
